/* design/mfp_irq_pkg.sv */
// Purpose: Shared constants, encodings and carriers for the multifunction pin and interrupt logic
// Assumes: Byte-wide registers with 16-bit addresses, written from the serial control port
// Notes: Function codes and sync/ignore locations are local encodings
package mfp_irq_pkg;

    localparam int NUM_PINS = 7;
    localparam int NUM_CAT = 5;
    localparam int SRC_PER_CAT = 8;
    localparam int NUM_SRC = NUM_CAT * SRC_PER_CAT;
    localparam int NUM_CHAN = 4;
    localparam int MISSING_PIN = 4;

    localparam logic [15:0] ADDR_IO_UPDATE = 16'h000f;
    localparam logic [7:0] IO_UPDATE_VAL = 8'h01;
    localparam logic [15:0] ADDR_DRV_LO = 16'h0100;
    localparam logic [15:0] ADDR_DRV_HI = 16'h0101;
    localparam logic [15:0] ADDR_FUNC_BASE = 16'h0103;
    localparam logic [15:0] ADDR_MASK_BASE = 16'h010f;
    localparam logic [15:0] ADDR_SYNC_CMD = 16'h0a02;
    localparam logic [15:0] ADDR_CH_IGNORE = 16'h0a03;
    localparam logic [15:0] ADDR_CLR_ALL = 16'h0a05;
    localparam logic [15:0] ADDR_CLR_BASE = 16'h0a06;
    localparam logic [15:0] ADDR_MON_BASE = 16'h0d08;
    localparam int CLR_ALL_BIT = 0;
    localparam int SYNC_CMD_BIT = 0;

    localparam logic [7:0] DRV_RST = 8'h00;
    localparam logic [7:0] FUNC_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] IGNORE_RST = 8'h00;

    // Drive modes; bit 1 also marks an OR term when the pin is an input
    localparam logic [1:0] DRV_ACT_HIGH = 2'h0;
    localparam logic [1:0] DRV_ACT_LOW = 2'h1;
    localparam logic [1:0] DRV_OD_HIGH = 2'h2;
    localparam logic [1:0] DRV_OD_LOW = 2'h3;

    localparam int FUNC_MON_BIT = 7;
    localparam logic [6:0] FN_OUT_IRQ_ALL = 7'h01;
    localparam logic [6:0] FN_OUT_IRQ_CAT0 = 7'h02;
    localparam logic [6:0] FN_IN_CLR_IRQ = 7'h01;
    localparam logic [6:0] FN_IN_SYNC = 7'h02;

    typedef struct packed {
        logic [1:0] mode;
        logic [7:0] func;
    } pin_cfg_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef enum {CH_HELD, CH_RUN, CH_IGNORING} ch_state_e;

    // Physical pin slot to pin number; number four does not exist
    function automatic int pin_num(input int p);
        return (p < MISSING_PIN) ? p : p + 1;
    endfunction

endpackage

/* design/mfp_pin_cell.sv */
// Purpose: Registered output stage of one multifunction pin
// Assumes: Pad logic resolves the wire from out and oe
// Notes: Output enable is high while this cell drives the pin
`timescale 1ns/1ps
`default_nettype none
module mfp_pin_cell (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic drive_en,
    input wire logic asserted,
    input wire logic [1:0] mode,
    output logic pin_out,
    output logic pin_oe
);
    import mfp_irq_pkg::*;

    logic nxt_out;
    logic nxt_oe;
    logic out_ff;
    logic oe_ff;

    always_comb begin
        nxt_out = 1'b0;
        nxt_oe = 1'b0;
        if (drive_en) begin
            case (mode)
                DRV_ACT_HIGH: begin
                    nxt_out = asserted;
                    nxt_oe = 1'b1;
                end
                DRV_ACT_LOW: begin
                    nxt_out = ~asserted;
                    nxt_oe = 1'b1;
                end
                DRV_OD_HIGH: begin
                    nxt_out = 1'b1;
                    nxt_oe = asserted;
                end
                default: begin
                    nxt_out = 1'b0;
                    nxt_oe = asserted;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            out_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
        end
    end

    assign pin_out = out_ff;
    assign pin_oe = oe_ff;
endmodule
`default_nettype wire

/* design/multifunction_pin_irq_logic.sv */
// Purpose: Multifunction pin configuration, interrupt collection and divider sync sources
// Assumes: irq_src and loop_locked come from logic on mclk; pin_in comes from pads
// Notes: Read data appears one cycle after a read strobe
// Summary of operation
// - Seven pins, none numbered four, configured through two drive-mode registers.
// - Writing a pin configuration stops its function until the next update strobe.
// - Mode 00 drives low when deasserted, high when asserted.
// - Mode 01 drives high when deasserted, low when asserted.
// - Mode 10 floats when deasserted, drives high when asserted; board pulls down.
// - Mode 11 floats when deasserted, drives low when asserted; board pulls up.
// - Function register MSB one makes the pin an output monitoring a function.
// - Function register MSB zero makes the pin an input controlling a function.
// - Pins zero to three keep two-bit drive modes in one register, ascending.
// - Pins sharing an input function combine through AND/OR terms, true or inverted.
// - A pin interrupt output follows one of five categories or all interrupts.
// - Monitor bit sets when source fires while its matching mask bit is set.
// - Clearing a mask bit stops capture but leaves monitor bits untouched.
// - Sources capture on rising edge; persisting condition does not re-set.
// - Enabling a mask while its source is present raises the interrupt.
// - Interrupt output is the OR of relevant monitor bits while any is set.
// - After reset all channel dividers stay held until a sync event.
// - A pin configured as sync input requests manual sync at any time.
// - Ignoring channels get one sync pulse at once, then disregard later syncs.
// - Clear registers map onto monitor bits one-to-one and read back zero.
// - Clear-all bit or clear-all pin clears every monitor bit.
`timescale 1ns/1ps
`default_nettype none
module multifunction_pin_irq_logic #(
    parameter int NUM_PINS = mfp_irq_pkg::NUM_PINS,
    parameter int NUM_CAT = mfp_irq_pkg::NUM_CAT,
    parameter int SRC_PER_CAT = mfp_irq_pkg::SRC_PER_CAT,
    parameter int NUM_CHAN = mfp_irq_pkg::NUM_CHAN
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire mfp_irq_pkg::reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    input wire logic [NUM_CAT*SRC_PER_CAT-1:0] irq_src,
    input wire logic [NUM_CHAN-1:0] loop_locked,
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0] pin_out,
    output logic [NUM_PINS-1:0] pin_oe,
    output logic [NUM_CHAN-1:0] chan_sync,
    output logic [NUM_CHAN-1:0] chan_hold
);
    import mfp_irq_pkg::*;

    localparam int NSRC = NUM_CAT * SRC_PER_CAT;

    // Configuration state
    logic [7:0] drv_lo_ff, nxt_drv_lo;
    logic [7:0] drv_hi_ff, nxt_drv_hi;
    logic [7:0] func_ff [NUM_PINS];
    logic [7:0] nxt_func [NUM_PINS];
    pin_cfg_s act_ff [NUM_PINS];
    pin_cfg_s nxt_act [NUM_PINS];
    logic [NUM_PINS-1:0] pend_ff, nxt_pend;
    logic [NUM_CHAN-1:0] ignore_ff, nxt_ignore;
    logic [7:0] rdata_ff, nxt_rdata;

    // Interrupt state
    logic [NSRC-1:0] mask_ff, nxt_mask;
    logic [NSRC-1:0] mon_ff, nxt_mon;
    logic [NSRC-1:0] gated_prev_ff;
    logic [NSRC-1:0] gated;
    logic [NSRC-1:0] clr_vec;
    logic clr_all_reg;

    // Pin input and sync state
    logic [NUM_PINS-1:0] pin_meta_ff, pin_sync_ff;
    logic sync_pin_prev_ff;
    logic [NUM_CHAN-1:0] lock_prev_ff;
    logic sync_cmd;
    logic sync_pin;
    logic clr_pin;
    logic sync_evt;
    ch_state_e ch_state_ff [NUM_CHAN];
    ch_state_e nxt_ch_state [NUM_CHAN];
    logic [NUM_CHAN-1:0] chan_sync_ff, nxt_chan_sync;
    logic [NUM_CHAN-1:0] chan_hold_ff, nxt_chan_hold;

    logic [NUM_PINS-1:0] in_clr_sel, in_sync_sel;
    logic [NUM_PINS-1:0] drive_en, asserted;
    logic [2*NUM_PINS-1:0] modes;

    // Drive-mode field of a pin from the two mode registers
    function automatic logic [1:0] drv_field(input logic [7:0] lo, input logic [7:0] hi,
                                             input int p);
        int n;
        n = pin_num(p);
        if (n < MISSING_PIN) begin
            return lo[2*n +: 2];
        end
        return hi[2*(n-MISSING_PIN-1) +: 2];
    endfunction

    // Mode bit 0 inverts the level, mode bit 1 puts the pin in the OR term
    function automatic logic combine_inputs(input logic [NUM_PINS-1:0] lvl,
                                            input logic [NUM_PINS-1:0] sel,
                                            input logic [2*NUM_PINS-1:0] m);
        logic and_t;
        logic or_t;
        logic any_or;
        logic any_sel;
        logic v;
        and_t = 1'b1;
        or_t = 1'b0;
        any_or = 1'b0;
        any_sel = 1'b0;
        v = 1'b0;
        for (int p = 0; p < NUM_PINS; p++) begin
            if (sel[p]) begin
                v = m[2*p] ? ~lvl[p] : lvl[p];
                any_sel = 1'b1;
                if (m[2*p+1]) begin
                    or_t = or_t | v;
                    any_or = 1'b1;
                end else begin
                    and_t = and_t & v;
                end
            end
        end
        return any_sel & and_t & (or_t | ~any_or);
    endfunction

    // Effective pin roles; a pending pin does nothing
    always_comb begin
        for (int p = 0; p < NUM_PINS; p++) begin
            modes[2*p +: 2] = act_ff[p].mode;
            drive_en[p] = ~pend_ff[p] & act_ff[p].func[FUNC_MON_BIT];
            in_clr_sel[p] = ~pend_ff[p] & ~act_ff[p].func[FUNC_MON_BIT]
                            & (act_ff[p].func[6:0] == FN_IN_CLR_IRQ);
            in_sync_sel[p] = ~pend_ff[p] & ~act_ff[p].func[FUNC_MON_BIT]
                             & (act_ff[p].func[6:0] == FN_IN_SYNC);
            asserted[p] = 1'b0;
            if (act_ff[p].func[6:0] == FN_OUT_IRQ_ALL) begin
                asserted[p] = |mon_ff;
            end
            for (int c = 0; c < NUM_CAT; c++) begin
                if (act_ff[p].func[6:0] == 7'(FN_OUT_IRQ_CAT0 + c)) begin
                    asserted[p] = |mon_ff[c*SRC_PER_CAT +: SRC_PER_CAT];
                end
            end
        end
        clr_pin = combine_inputs(pin_sync_ff, in_clr_sel, modes);
        sync_pin = combine_inputs(pin_sync_ff, in_sync_sel, modes);
    end

    // Register access; the clear and command registers are write-only pulses
    always_comb begin
        nxt_drv_lo = drv_lo_ff;
        nxt_drv_hi = drv_hi_ff;
        nxt_func = func_ff;
        nxt_act = act_ff;
        nxt_pend = pend_ff;
        nxt_ignore = ignore_ff;
        nxt_mask = mask_ff;
        nxt_rdata = rdata_ff;
        clr_vec = '0;
        clr_all_reg = 1'b0;
        sync_cmd = 1'b0;
        if (reg_req.wr) begin
            if (reg_req.addr == ADDR_IO_UPDATE) begin
                if (reg_req.wdata == IO_UPDATE_VAL) begin
                    for (int p = 0; p < NUM_PINS; p++) begin
                        nxt_act[p].mode = drv_field(drv_lo_ff, drv_hi_ff, p);
                        nxt_act[p].func = func_ff[p];
                    end
                    nxt_pend = '0;
                end
            end else if (reg_req.addr == ADDR_DRV_LO) begin
                nxt_drv_lo = reg_req.wdata;
                for (int p = 0; p < NUM_PINS; p++) begin
                    if (pin_num(p) < MISSING_PIN) begin
                        nxt_pend[p] = 1'b1;
                    end
                end
            end else if (reg_req.addr == ADDR_DRV_HI) begin
                nxt_drv_hi = reg_req.wdata;
                for (int p = 0; p < NUM_PINS; p++) begin
                    if (pin_num(p) > MISSING_PIN) begin
                        nxt_pend[p] = 1'b1;
                    end
                end
            end else if (reg_req.addr == ADDR_SYNC_CMD) begin
                sync_cmd = reg_req.wdata[SYNC_CMD_BIT];
            end else if (reg_req.addr == ADDR_CH_IGNORE) begin
                nxt_ignore = reg_req.wdata[NUM_CHAN-1:0];
            end else if (reg_req.addr == ADDR_CLR_ALL) begin
                clr_all_reg = reg_req.wdata[CLR_ALL_BIT];
            end
            for (int p = 0; p < NUM_PINS; p++) begin
                if (reg_req.addr == ADDR_FUNC_BASE + 16'(pin_num(p))) begin
                    nxt_func[p] = reg_req.wdata;
                    nxt_pend[p] = 1'b1;
                end
            end
            for (int c = 0; c < NUM_CAT; c++) begin
                if (reg_req.addr == ADDR_MASK_BASE + 16'(c)) begin
                    nxt_mask[c*SRC_PER_CAT +: SRC_PER_CAT] = reg_req.wdata;
                end
                if (reg_req.addr == ADDR_CLR_BASE + 16'(c)) begin
                    clr_vec[c*SRC_PER_CAT +: SRC_PER_CAT] = reg_req.wdata;
                end
            end
        end
        if (reg_req.rd) begin
            nxt_rdata = 8'h00;
            if (reg_req.addr == ADDR_DRV_LO) begin
                nxt_rdata = drv_lo_ff;
            end else if (reg_req.addr == ADDR_DRV_HI) begin
                nxt_rdata = drv_hi_ff;
            end else if (reg_req.addr == ADDR_CH_IGNORE) begin
                nxt_rdata[NUM_CHAN-1:0] = ignore_ff;
            end
            for (int p = 0; p < NUM_PINS; p++) begin
                if (reg_req.addr == ADDR_FUNC_BASE + 16'(pin_num(p))) begin
                    nxt_rdata = func_ff[p];
                end
            end
            for (int c = 0; c < NUM_CAT; c++) begin
                if (reg_req.addr == ADDR_MASK_BASE + 16'(c)) begin
                    nxt_rdata = mask_ff[c*SRC_PER_CAT +: SRC_PER_CAT];
                end
                if (reg_req.addr == ADDR_MON_BASE + 16'(c)) begin
                    nxt_rdata = mon_ff[c*SRC_PER_CAT +: SRC_PER_CAT];
                end
            end
        end
    end

    // Edge of the gated source, so unmasking a standing condition counts as an edge
    always_comb begin
        gated = irq_src & mask_ff;
        nxt_mon = mon_ff & ~clr_vec;
        if (clr_all_reg | clr_pin) begin
            nxt_mon = '0;
        end
        nxt_mon = nxt_mon | (gated & ~gated_prev_ff);
    end

    // Channel sync sequencing
    always_comb begin
        sync_evt = sync_cmd | (sync_pin & ~sync_pin_prev_ff)
                   | (|(loop_locked & ~lock_prev_ff));
        for (int c = 0; c < NUM_CHAN; c++) begin
            nxt_ch_state[c] = ch_state_ff[c];
            nxt_chan_sync[c] = 1'b0;
            case (ch_state_ff[c])
                CH_HELD, CH_RUN: begin
                    if (ignore_ff[c]) begin
                        nxt_chan_sync[c] = 1'b1;
                        nxt_ch_state[c] = CH_IGNORING;
                    end else if (sync_evt) begin
                        nxt_chan_sync[c] = 1'b1;
                        nxt_ch_state[c] = CH_RUN;
                    end
                end
                CH_IGNORING: begin
                    if (!ignore_ff[c]) begin
                        nxt_ch_state[c] = CH_RUN;
                    end
                end
                default: nxt_ch_state[c] = CH_HELD;
            endcase
            nxt_chan_hold[c] = (nxt_ch_state[c] == CH_HELD);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            drv_lo_ff <= DRV_RST;
            drv_hi_ff <= DRV_RST;
            pend_ff <= '0;
            ignore_ff <= IGNORE_RST[NUM_CHAN-1:0];
            rdata_ff <= 8'h00;
            mask_ff <= '0;
            mon_ff <= '0;
            gated_prev_ff <= '0;
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
            sync_pin_prev_ff <= 1'b0;
            lock_prev_ff <= '0;
            chan_sync_ff <= '0;
            chan_hold_ff <= '1;
            for (int p = 0; p < NUM_PINS; p++) begin
                func_ff[p] <= FUNC_RST;
                act_ff[p] <= '{mode: DRV_ACT_HIGH, func: FUNC_RST};
            end
            for (int c = 0; c < NUM_CHAN; c++) begin
                ch_state_ff[c] <= CH_HELD;
            end
        end else begin
            drv_lo_ff <= nxt_drv_lo;
            drv_hi_ff <= nxt_drv_hi;
            func_ff <= nxt_func;
            act_ff <= nxt_act;
            pend_ff <= nxt_pend;
            ignore_ff <= nxt_ignore;
            rdata_ff <= nxt_rdata;
            mask_ff <= nxt_mask;
            mon_ff <= nxt_mon;
            gated_prev_ff <= gated;
            pin_meta_ff <= pin_in;
            pin_sync_ff <= pin_meta_ff;
            sync_pin_prev_ff <= sync_pin;
            lock_prev_ff <= loop_locked;
            chan_sync_ff <= nxt_chan_sync;
            chan_hold_ff <= nxt_chan_hold;
            ch_state_ff <= nxt_ch_state;
        end
    end

    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        mfp_pin_cell u_cell (
            .mclk(mclk),
            .rst_b(rst_b),
            .drive_en(drive_en[p]),
            .asserted(asserted[p]),
            .mode(act_ff[p].mode),
            .pin_out(pin_out[p]),
            .pin_oe(pin_oe[p])
        );
    end

    assign reg_rdata = rdata_ff;
    assign chan_sync = chan_sync_ff;
    assign chan_hold = chan_hold_ff;
endmodule
`default_nettype wire

/* sim/board_pins.sv */
// Purpose: Board model of the multifunction pin pads
// Assumes: Every pad has a pull resistor on the board
// Notes: A driving pin wins over the external source
`timescale 1ns/1ps
`default_nettype none
module board_pins #(
    parameter logic [6:0] PULL_UP = 7'h7b
) (
    input wire logic [6:0] pin_out,
    input wire logic [6:0] pin_oe,
    input wire logic [6:0] ext_en,
    input wire logic [6:0] ext_val,
    output logic [6:0] pad
);
    // Released pads go to the external value if enabled, else to the pull level, never to the last value
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            if (pin_oe[i]) begin
                pad[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pad[i] = ext_val[i];
            end else begin
                pad[i] = PULL_UP[i];
            end
        end
    end
endmodule
`default_nettype wire

/* sim/mfp_irq_properties.sv */
// Purpose: Port checks of the multifunction pin and interrupt block
// Assumes: One clock domain, reset low and asynchronous
// Notes: Ignore bits are shadowed from the write strobes
`timescale 1ns/1ps
`default_nettype none
module mfp_irq_properties #(
    parameter int NUM_PINS = mfp_irq_pkg::NUM_PINS,
    parameter int NUM_CAT = mfp_irq_pkg::NUM_CAT,
    parameter int SRC_PER_CAT = mfp_irq_pkg::SRC_PER_CAT,
    parameter int NUM_CHAN = mfp_irq_pkg::NUM_CHAN
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire mfp_irq_pkg::reg_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic [NUM_CAT*SRC_PER_CAT-1:0] irq_src,
    input wire logic [NUM_CHAN-1:0] loop_locked,
    input wire logic [NUM_PINS-1:0] pin_in,
    input wire logic [NUM_PINS-1:0] pin_out,
    input wire logic [NUM_PINS-1:0] pin_oe,
    input wire logic [NUM_CHAN-1:0] chan_sync,
    input wire logic [NUM_CHAN-1:0] chan_hold
);
    import mfp_irq_pkg::*;
    logic [NUM_CHAN-1:0] ign_ff;
    logic [NUM_CHAN-1:0] nxt_ign;
    always_comb begin
        nxt_ign = ign_ff;
        if (reg_req.wr && reg_req.addr == ADDR_CH_IGNORE) begin
            nxt_ign = reg_req.wdata[NUM_CHAN-1:0];
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ign_ff <= '0;
        end else begin
            ign_ff <= nxt_ign;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    a_hold_drop: assert property (($past(chan_hold) & ~chan_hold & ~chan_sync) == '0)
        else $error("hold dropped without sync");
    a_hold_no_rise: assert property ((~$past(chan_hold) & chan_hold) == '0)
        else $error("hold came back");
    a_cmd_sync: assert property (
        reg_req.wr && reg_req.addr == ADDR_SYNC_CMD && reg_req.wdata[SYNC_CMD_BIT]
        |-> ##[1:3] ((chan_sync | ign_ff) == '1)) else $error("no command sync");
    a_lock_sync: assert property (
        (loop_locked & ~$past(loop_locked)) != '0 |-> ##[1:3] ((chan_sync | ign_ff) == '1))
        else $error("no lock sync");
    a_ignore_quiet: assert property (
        (chan_sync & ign_ff & $past(ign_ff) & $past(ign_ff, 2) & $past(ign_ff, 3)) == '0)
        else $error("ignoring channel pulsed");
    a_rdata_holds: assert property (!reg_req.rd |=> $stable(reg_rdata))
        else $error("read data moved");
    a_clr_reads_zero: assert property (
        reg_req.rd && reg_req.addr inside {[ADDR_CLR_ALL:ADDR_CLR_BASE + 16'h0004]}
        |=> reg_rdata == 8'h00) else $error("clear register not zero");
    a_unmapped_zero: assert property (
        reg_req.rd && reg_req.addr inside {[16'h0200:16'h09ff]} |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_lo_pins_stop: assert property (
        reg_req.wr && reg_req.addr == ADDR_DRV_LO |-> ##[1:2] pin_oe[3:0] == 4'h0)
        else $error("low pins kept driving");
    a_hi_pins_stop: assert property (
        reg_req.wr && reg_req.addr == ADDR_DRV_HI |-> ##[1:2] pin_oe[6:4] == 3'h0)
        else $error("high pins kept driving");
endmodule
bind multifunction_pin_irq_logic mfp_irq_properties #(.NUM_PINS(NUM_PINS), .NUM_CAT(NUM_CAT),
    .SRC_PER_CAT(SRC_PER_CAT), .NUM_CHAN(NUM_CHAN)) u_props (.mclk(mclk), .rst_b(rst_b),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .irq_src(irq_src), .loop_locked(loop_locked),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .chan_sync(chan_sync),
    .chan_hold(chan_hold));
`default_nettype wire

/* sim/tb_top.sv */
// Purpose: Directed register and pin bench for the multifunction pin block
// Assumes: Pads pulled up except pin two, which is pulled down
// Notes: Tasks drive on the rising edge and sample one step after it
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import mfp_irq_pkg::*;
    logic mclk;
    logic rst_b;
    reg_req_s reg_req;
    logic [7:0] reg_rdata;
    logic [NUM_SRC-1:0] irq_src;
    logic [NUM_CHAN-1:0] loop_locked;
    logic [6:0] pad;
    logic [6:0] pin_out;
    logic [6:0] pin_oe;
    logic [6:0] ext_en;
    logic [6:0] ext_val;
    logic [3:0] chan_sync;
    logic [3:0] chan_hold;
    int bad_count;
    int n_checks;
    int sync_n [4];
    int snap_n [4];
    multifunction_pin_irq_logic dut (.mclk(mclk), .rst_b(rst_b), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .irq_src(irq_src), .loop_locked(loop_locked), .pin_in(pad),
        .pin_out(pin_out), .pin_oe(pin_oe), .chan_sync(chan_sync), .chan_hold(chan_hold));
    board_pins u_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
        .ext_val(ext_val), .pad(pad));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        for (int i = 0; i < 4; i++) begin
            if (chan_sync[i] === 1'b1) begin
                sync_n[i]++;
            end
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        reg_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        reg_req.rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    // Each channel set in exp must pulse exactly once, each other one not at all
    task automatic sync_chk(input logic [3:0] exp);
        logic [3:0] got;
        cyc(8);
        for (int i = 0; i < 4; i++) begin
            got[i] = (sync_n[i] - snap_n[i]) == (exp[i] ? 1 : 0);
        end
        chk({4'h0, got}, 8'h0f);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        conclude();
    end
    initial begin
        rst_b = 1'b0;
        reg_req = '0;
        irq_src = '0;
        loop_locked = '0;
        ext_en = '0;
        ext_val = '0;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        cyc(1);
        chk({4'h0, chan_hold}, 8'h0f);
        chk({1'b0, pin_oe}, 8'h00);
        rd(ADDR_DRV_LO, DRV_RST);
        rd(ADDR_MASK_BASE, MASK_RST);
        rd(16'h0200, 8'h00);
        wr(16'h0107, 8'h81);
        rd(16'h0107, 8'h00);
        snap_n = sync_n;
        wr(ADDR_CH_IGNORE, 8'h03);
        sync_chk(4'h3);
        chk({4'h0, chan_hold}, 8'h0c);
        snap_n = sync_n;
        wr(ADDR_SYNC_CMD, 8'h01);
        sync_chk(4'hc);
        chk({4'h0, chan_hold}, 8'h00);
        wr(ADDR_FUNC_BASE, 8'h81);
        wr(ADDR_FUNC_BASE + 16'h1, 8'h82);
        wr(ADDR_FUNC_BASE + 16'h2, 8'h86);
        wr(ADDR_FUNC_BASE + 16'h3, 8'h81);
        wr(ADDR_DRV_LO, 8'he4);
        rd(ADDR_DRV_LO, 8'he4);
        wr(ADDR_IO_UPDATE, 8'h02);
        cyc(3);
        chk({1'b0, pin_oe}, 8'h00);
        wr(ADDR_IO_UPDATE, IO_UPDATE_VAL);
        cyc(3);
        chk({4'h0, pad[3:0]}, 8'h0a);
        chk({4'h0, pin_oe[3:0]}, 8'h03);
        @(posedge mclk);
        irq_src[0] <= 1'b1;
        cyc(4);
        chk({4'h0, pad[3:0]}, 8'h0a);
        wr(ADDR_MASK_BASE, 8'h01);
        cyc(4);
        chk({4'h0, pad[3:0]}, 8'h01);
        chk({4'h0, pin_oe[3:0]}, 8'h0b);
        rd(ADDR_MON_BASE, 8'h01);
        wr(ADDR_CLR_BASE, 8'h01);
        cyc(4);
        rd(ADDR_MON_BASE, 8'h00);
        rd(ADDR_CLR_BASE, 8'h00);
        @(posedge mclk);
        irq_src[0] <= 1'b0;
        @(posedge mclk);
        irq_src[0] <= 1'b1;
        cyc(4);
        wr(ADDR_MASK_BASE, 8'h00);
        cyc(4);
        rd(ADDR_MON_BASE, 8'h01);
        @(posedge mclk);
        irq_src[32] <= 1'b1;
        wr(ADDR_MASK_BASE + 16'h4, 8'h01);
        cyc(4);
        chk({7'h0, pad[2]}, 8'h01);
        rd(ADDR_MON_BASE + 16'h4, 8'h01);
        wr(ADDR_CLR_ALL, 8'h01);
        cyc(4);
        rd(ADDR_MON_BASE, 8'h00);
        rd(ADDR_MON_BASE + 16'h4, 8'h00);
        rd(ADDR_CLR_ALL, 8'h00);
        chk({4'h0, pad[3:0]}, 8'h0a);
        // Rewriting the modes of live pins must silence them until the next update
        wr(ADDR_DRV_LO, 8'he4);
        cyc(2);
        chk({4'h0, pin_oe[3:0]}, 8'h00);
        wr(ADDR_IO_UPDATE, IO_UPDATE_VAL);
        cyc(3);
        chk({4'h0, pin_oe[3:0]}, 8'h03);
        wr(ADDR_MASK_BASE + 16'h4, 8'h03);
        @(posedge mclk);
        irq_src[33] <= 1'b1;
        ext_en <= 7'h70;
        ext_val <= 7'h30;
        wr(ADDR_FUNC_BASE + 16'h5, 8'h01);
        wr(ADDR_FUNC_BASE + 16'h6, 8'h01);
        wr(ADDR_FUNC_BASE + 16'h7, 8'h02);
        // Pin five joins the AND term true, pin six the OR term inverted
        wr(ADDR_DRV_HI, 8'h0c);
        rd(ADDR_DRV_HI, 8'h0c);
        wr(ADDR_IO_UPDATE, IO_UPDATE_VAL);
        cyc(8);
        rd(ADDR_MON_BASE + 16'h4, 8'h02);
        @(posedge mclk);
        ext_val <= 7'h10;
        cyc(8);
        rd(ADDR_MON_BASE + 16'h4, 8'h00);
        snap_n = sync_n;
        @(posedge mclk);
        ext_val <= 7'h70;
        sync_chk(4'hc);
        snap_n = sync_n;
        @(posedge mclk);
        loop_locked <= 4'h1;
        sync_chk(4'hc);
        wr(ADDR_CH_IGNORE, 8'h00);
        snap_n = sync_n;
        wr(ADDR_SYNC_CMD, 8'h01);
        sync_chk(4'hf);
        conclude();
    end
endmodule
`default_nettype wire
